/* File: rtl/output_terminal.sv */
// One output terminal: function select and logic polarity
`default_nettype none

module output_terminal
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	// Selected code and function states
	input  wire logic [13:0] code,
	input  wire logic [99:0] func_state,
	// Terminal level
	output var  logic        pin_q
);

	logic       neg;
	logic [6:0] idx;
	logic       none;

	// Fold the negative-logic codes back onto their base function
	always_comb
	begin
		neg  = (code >= start_stop_pkg::OUT_NEG_BASE) && (code <= start_stop_pkg::OUT_NEG_MAX);
		none = (code > start_stop_pkg::OUT_NEG_MAX);
		if (neg)
		begin
			idx = 7'(code - start_stop_pkg::OUT_NEG_BASE);
		end
		else
		begin
			idx = code[6:0];
		end
	end

	// Registered so the pin never glitches while the code changes
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
			pin_q <= 1'b0;
		else if (none)
			pin_q <= 1'b0;
		else
			pin_q <= func_state[idx] ^ neg;
	end

endmodule : output_terminal

`default_nettype wire

/* File: rtl/start_stop_logic.sv */
// Start, stop and output terminal command logic of the motor drive
`default_nettype none

module start_stop_logic
#(
	parameter int unsigned CYC_PER_SEC = start_stop_pkg::CYC_PER_SEC
)
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	// Input terminals and their function selections
	input  wire logic [4:0]  term_in,
	input  wire logic [7:0]  input_terminal_select_first,
	input  wire logic [7:0]  input_terminal_select_second,
	input  wire logic [23:0] other_terminal_select,
	input  wire logic        jog_enable,
	// Setting writes
	input  wire logic [13:0] extended_display_select,
	input  wire logic        stop_sel_wr,
	input  wire logic        oc_sel_wr,
	input  wire logic        relay_sel_wr,
	input  wire logic [13:0] setting_wdata,
	// Drive status for the output terminals
	input  wire logic [99:0] func_state,
	input  wire logic        fault_in,
	// Setting readback
	output var  logic [13:0] stop_selection_setting,
	output var  logic [13:0] open_collector_output_select,
	output var  logic [13:0] relay_output_select,
	// Motor commands
	output var  logic        run_q,
	output var  logic        dir_rev_q,
	output var  logic        decel_q,
	output var  logic        coast_q,
	output var  logic        shutoff_q,
	output var  logic        second_set_select,
	// Output terminals
	output var  logic        open_collector_pin,
	output var  logic        fault_relay_output
);

	// ----------------------------------------------------------------
	// Input terminal decode
	// ----------------------------------------------------------------
	logic [7:0] term_sel [start_stop_pkg::NUM_TERM];
	logic [4:0] hit_stop;
	logic [4:0] hit_shut;
	logic [4:0] hit_second;
	logic [4:0] hit_jog;
	logic       forward_start_input;
	logic       reverse_start_input;
	logic       stop_assigned;
	logic       stop_in;
	logic       output_shutoff_input;
	logic       jog_in;

	assign term_sel[0] = input_terminal_select_first;
	assign term_sel[1] = input_terminal_select_second;

	// Same function on several terminals is ORed
	genvar gi;
	generate
		for (gi = 0; gi < start_stop_pkg::NUM_TERM; gi++)
		begin : g_term
			if (gi >= 2)
			begin : g_other
				assign term_sel[gi] = other_terminal_select[(gi-2)*8 +: 8];
			end
			assign hit_stop[gi]   = (term_sel[gi] == start_stop_pkg::FUNC_STOP);
			assign hit_shut[gi]   = (term_sel[gi] == start_stop_pkg::FUNC_SHUTOFF);
			assign hit_second[gi] = (term_sel[gi] == start_stop_pkg::FUNC_SECOND);
			assign hit_jog[gi]    = (term_sel[gi] == start_stop_pkg::FUNC_JOG);
		end
	endgenerate

	// Start functions live only on their own two terminals
	assign forward_start_input  = term_in[0] && (term_sel[0] == start_stop_pkg::FUNC_FWD);
	assign reverse_start_input  = term_in[1] && (term_sel[1] == start_stop_pkg::FUNC_REV);
	assign stop_assigned        = |hit_stop;
	assign stop_in              = |(hit_stop & term_in);
	assign output_shutoff_input = |(hit_shut & term_in);
	assign jog_in               = |(hit_jog & term_in) && jog_enable;

	// ----------------------------------------------------------------
	// Settings
	// ----------------------------------------------------------------
	logic stop_valid;
	logic oc_valid;
	logic relay_valid;
	logic [13:0] wbase;
	logic        wbase_ok;

	// Accepted output codes, positive half; negative half folds onto it
	always_comb
	begin
		wbase = setting_wdata;
		if (setting_wdata >= start_stop_pkg::OUT_NEG_BASE)
			wbase = 14'(setting_wdata - start_stop_pkg::OUT_NEG_BASE);
		case (wbase)
			14'd0, 14'd1, 14'd3, 14'd4, 14'd7, 14'd8, 14'd11, 14'd12,
			14'd13, 14'd14, 14'd15, 14'd16, 14'd25, 14'd26, 14'd46,
			14'd47, 14'd64, 14'd70, 14'd80, 14'd90, 14'd91, 14'd93,
			14'd95, 14'd96, 14'd98, 14'd99:
				wbase_ok = 1'b1;
			default:
				wbase_ok = 1'b0;
		endcase
		if (setting_wdata > start_stop_pkg::OUT_NEG_MAX)
			wbase_ok = 1'b0;
	end

	assign stop_valid = (setting_wdata <= start_stop_pkg::STOP_SEL_TIME_MAX)
		|| ((setting_wdata >= start_stop_pkg::STOP_SEL_DIR_MIN)
		&& (setting_wdata <= start_stop_pkg::STOP_SEL_DIR_MAX))
		|| (setting_wdata == start_stop_pkg::STOP_SEL_DECEL)
		|| (setting_wdata == start_stop_pkg::STOP_SEL_DIR_DECEL);
	assign oc_valid    = wbase_ok || (setting_wdata == start_stop_pkg::OUT_NONE);
	assign relay_valid = oc_valid && (wbase != start_stop_pkg::OUT_OC_ONLY);

	// Stop selection; locked unless the extended display select is zero
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
			stop_selection_setting <= start_stop_pkg::STOP_SEL_INIT;
		else if (stop_sel_wr && stop_valid && (extended_display_select == 14'd0))
			stop_selection_setting <= setting_wdata;
	end

	// Output function selections, same write lock as the stop selection
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			open_collector_output_select <= start_stop_pkg::OC_SEL_INIT;
			relay_output_select          <= start_stop_pkg::RELAY_SEL_INIT;
		end
		else if (extended_display_select == 14'd0)
		begin
			if (oc_sel_wr && oc_valid)
				open_collector_output_select <= setting_wdata;
			if (relay_sel_wr && relay_valid)
				relay_output_select <= setting_wdata;
		end
	end

	// ----------------------------------------------------------------
	// Mode decode
	// ----------------------------------------------------------------
	logic        run_dir_mode;
	logic        timed_mode;
	logic        coast_mode;
	logic [13:0] delay_sec;
	logic        three_wire;

	assign timed_mode = (stop_selection_setting <= start_stop_pkg::STOP_SEL_TIME_MAX);
	assign run_dir_mode = (stop_selection_setting >= start_stop_pkg::STOP_SEL_DIR_MIN)
		&& (stop_selection_setting <= start_stop_pkg::STOP_SEL_DIR_MAX)
		|| (stop_selection_setting == start_stop_pkg::STOP_SEL_DIR_DECEL);
	assign coast_mode = timed_mode || (run_dir_mode
		&& (stop_selection_setting != start_stop_pkg::STOP_SEL_DIR_DECEL));
	assign delay_sec = timed_mode ? stop_selection_setting
		: 14'(stop_selection_setting - start_stop_pkg::STOP_SEL_DIR_MIN);

	// Jog makes the stop input invalid, which drops back to two-wire
	assign three_wire = stop_assigned && !jog_in;

	// ----------------------------------------------------------------
	// Three-wire self-holding latch
	// ----------------------------------------------------------------
	logic fwd_prev_q;
	logic rev_prev_q;
	logic latch_q;
	logic latch_rev_q;
	logic fwd_rise;
	logic rev_rise;

	assign fwd_rise = forward_start_input && !fwd_prev_q;
	assign rev_rise = reverse_start_input && !rev_prev_q;

	// Edge history of the start inputs
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			fwd_prev_q <= 1'b0;
			rev_prev_q <= 1'b0;
		end
		else
		begin
			fwd_prev_q <= forward_start_input;
			rev_prev_q <= reverse_start_input;
		end
	end

	// Shutoff is deliberately absent here so the hold survives it
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			latch_q     <= 1'b0;
			latch_rev_q <= 1'b0;
		end
		else if (!three_wire || !stop_in)
		begin
			latch_q     <= 1'b0;
			latch_rev_q <= 1'b0;
		end
		else if (run_dir_mode)
		begin
			if (fwd_rise)
				latch_q <= 1'b1;
			latch_rev_q <= reverse_start_input;
		end
		else if (fwd_rise)
		begin
			latch_q     <= 1'b1;
			latch_rev_q <= 1'b0;
		end
		else if (rev_rise)
		begin
			latch_q     <= 1'b1;
			latch_rev_q <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Start command
	// ----------------------------------------------------------------
	logic start_cmd;
	logic start_rev;
	logic both_on;

	assign both_on = forward_start_input && reverse_start_input;

	// Three-wire runs from the latch, otherwise from the input levels
	always_comb
	begin
		if (three_wire)
		begin
			start_cmd = latch_q;
			start_rev = latch_rev_q;
		end
		else if (run_dir_mode)
		begin
			start_cmd = forward_start_input;
			start_rev = reverse_start_input;
		end
		else
		begin
			start_cmd = forward_start_input ^ reverse_start_input;
			start_rev = reverse_start_input;
		end
	end

	// ----------------------------------------------------------------
	// Coast delay timer
	// ----------------------------------------------------------------
	logic [31:0] presc_q;
	logic [13:0] sec_q;
	logic        delay_done;
	start_stop_pkg::drive_state_t state_q;

	assign delay_done = (sec_q >= delay_sec);

	// Whole seconds counted during the delay state only
	always_ff @(posedge sys_clk)
	begin
		if (!nrst || (state_q != start_stop_pkg::ST_DELAY))
		begin
			presc_q <= 32'h0000_0000;
			sec_q   <= 14'h0000;
		end
		else if (presc_q == 32'(CYC_PER_SEC - 1))
		begin
			presc_q <= 32'h0000_0000;
			sec_q   <= 14'(sec_q + 14'd1);
		end
		else
		begin
			presc_q <= 32'(presc_q + 32'd1);
		end
	end

	// ----------------------------------------------------------------
	// Drive state machine
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			state_q   <= start_stop_pkg::ST_IDLE;
			dir_rev_q <= 1'b0;
		end
		else if (start_cmd && !output_shutoff_input)
		begin
			state_q   <= start_stop_pkg::ST_RUN;
			dir_rev_q <= start_rev;
		end
		else if (output_shutoff_input)
		begin
			state_q <= start_stop_pkg::ST_COAST;
		end
		else
		begin
			case (state_q)
				start_stop_pkg::ST_RUN:
					if (!three_wire && !run_dir_mode && both_on)
						state_q <= start_stop_pkg::ST_DECEL;
					else if (coast_mode && !three_wire)
						state_q <= start_stop_pkg::ST_DELAY;
					else
						state_q <= start_stop_pkg::ST_DECEL;
				start_stop_pkg::ST_DELAY:
					if (delay_done)
						state_q <= start_stop_pkg::ST_COAST;
				start_stop_pkg::ST_DECEL,
				start_stop_pkg::ST_COAST,
				start_stop_pkg::ST_IDLE:
					state_q <= state_q;
				default:
					state_q <= start_stop_pkg::ST_IDLE;
			endcase
		end
	end

	// Motor command flags, all registered
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			run_q     <= 1'b0;
			decel_q   <= 1'b0;
			coast_q   <= 1'b0;
			shutoff_q <= 1'b0;
		end
		else
		begin
			run_q     <= (state_q == start_stop_pkg::ST_RUN);
			decel_q   <= (state_q == start_stop_pkg::ST_DECEL)
				|| (state_q == start_stop_pkg::ST_DELAY);
			coast_q   <= (state_q == start_stop_pkg::ST_COAST);
			shutoff_q <= output_shutoff_input;
		end
	end

	// Second set: one flag switches every paired value together
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
			second_set_select <= 1'b0;
		else
			second_set_select <= |(hit_second & term_in);
	end

	// ----------------------------------------------------------------
	// Output terminals
	// ----------------------------------------------------------------
	logic [99:0] func_live;

	// Running and fault come from this block, the rest from the drive
	always_comb
	begin
		func_live = func_state;
		func_live[start_stop_pkg::OUT_RUNNING] = (state_q == start_stop_pkg::ST_RUN);
		func_live[start_stop_pkg::OUT_FAULT]   = fault_in;
	end

	output_terminal u_oc
	(
		.sys_clk    (sys_clk),
		.nrst       (nrst),
		.code       (open_collector_output_select),
		.func_state (func_live),
		.pin_q      (open_collector_pin)
	);

	output_terminal u_relay
	(
		.sys_clk    (sys_clk),
		.nrst       (nrst),
		.code       (relay_output_select),
		.func_state (func_live),
		.pin_q      (fault_relay_output)
	);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_lock;
		@(posedge sys_clk) disable iff (!nrst)
		(stop_sel_wr && (extended_display_select != 14'd0)) |=> $stable(stop_selection_setting);
	endproperty
	a_lock: assert property (p_lock) else $error("stop selection changed while locked");

	property p_bad_stop;
		@(posedge sys_clk) disable iff (!nrst)
		(stop_sel_wr && !stop_valid) |=> $stable(stop_selection_setting);
	endproperty
	a_bad_stop: assert property (p_bad_stop) else $error("invalid stop value taken");

	property p_relay_93;
		@(posedge sys_clk) disable iff (!nrst)
		(relay_sel_wr && ((setting_wdata == 14'd93) || (setting_wdata == 14'd193)))
		|=> $stable(relay_output_select);
	endproperty
	a_relay_93: assert property (p_relay_93) else $error("relay took open collector code");

	property p_both_decel;
		@(posedge sys_clk) disable iff (!nrst)
		(state_q == start_stop_pkg::ST_RUN && !three_wire && !run_dir_mode && both_on
		&& !output_shutoff_input) |=> (state_q == start_stop_pkg::ST_DECEL) ##1 decel_q;
	endproperty
	a_both_decel: assert property (p_both_decel) else $error("both inputs did not decelerate");

	property p_rev_run;
		@(posedge sys_clk) disable iff (!nrst)
		(!three_wire && run_dir_mode && forward_start_input && reverse_start_input
		&& !output_shutoff_input) |=> dir_rev_q ##1 run_q;
	endproperty
	a_rev_run: assert property (p_rev_run) else $error("run plus direction not reverse");

	property p_hold_shutoff;
		@(posedge sys_clk) disable iff (!nrst)
		(latch_q && three_wire && stop_in && output_shutoff_input && $stable(three_wire))
		|=> latch_q;
	endproperty
	a_hold_shutoff: assert property (p_hold_shutoff) else $error("shutoff cleared latch");

	property p_stop_clear;
		@(posedge sys_clk) disable iff (!nrst)
		(three_wire && !stop_in) |=> !latch_q;
	endproperty
	a_stop_clear: assert property (p_stop_clear) else $error("latch kept after stop");

	property p_decel_init;
		@(posedge sys_clk) disable iff (!nrst)
		(state_q == start_stop_pkg::ST_RUN && !start_cmd && !output_shutoff_input
		&& stop_selection_setting == start_stop_pkg::STOP_SEL_DECEL)
		|=> (state_q == start_stop_pkg::ST_DECEL);
	endproperty
	a_decel_init: assert property (p_decel_init) else $error("9999 did not decelerate");

	property p_second;
		@(posedge sys_clk) disable iff (!nrst)
		|(hit_second & term_in) |=> second_set_select;
	endproperty
	a_second: assert property (p_second) else $error("second set not selected");

endmodule : start_stop_logic

`default_nettype wire

/* File: rtl/start_stop_pkg.sv */
// Constants shared by the start and stop command logic of the motor drive
//
// How it works
// - Setting 0-100: two-wire, coast after delay
// - Setting 1000-1100: coast after setting minus 1000
// - Setting 9999: start removal decelerates to stop
// - 1000-1100 or 8888: run plus direction inputs
// - Two-wire both on, or both off at 9999: decelerate
// - Run off stops; direction picks forward/reverse
// - Stop input active enables start self-holding
// - Start pulse latches run; opposite pulse reverses
// - Stop input released clears latch, decelerates
// - Stop function only from terminal code 25
// - Output shutoff keeps the three-wire latch
// - Active jog makes stop input ignored
// - Forward/reverse start only on their own terminals
// - Second-set input switches all second values
// - Output defaults: running code 0, fault 99
// - Relay select refuses codes 93 and 193
// - Stop selection writable only when display is 0
// - Codes 0-99 positive, 100-199 negative logic
`default_nettype none

package start_stop_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 5;
	localparam int unsigned ONE_SEC_NS    = 1000000000;
	localparam int unsigned CYC_PER_SEC   = ONE_SEC_NS / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// Stop selection values
	// ----------------------------------------------------------------
	localparam logic [13:0] STOP_SEL_INIT      = 14'd9999;
	localparam logic [13:0] STOP_SEL_DECEL     = 14'd9999;
	localparam logic [13:0] STOP_SEL_DIR_DECEL = 14'd8888;
	localparam logic [13:0] STOP_SEL_TIME_MAX  = 14'd100;
	localparam logic [13:0] STOP_SEL_DIR_MIN   = 14'd1000;
	localparam logic [13:0] STOP_SEL_DIR_MAX   = 14'd1100;

	// ----------------------------------------------------------------
	// Output terminal function codes
	// ----------------------------------------------------------------
	localparam logic [13:0] OC_SEL_INIT    = 14'd0;
	localparam logic [13:0] RELAY_SEL_INIT = 14'd99;
	localparam logic [13:0] OUT_NONE       = 14'd9999;
	localparam logic [13:0] OUT_NEG_BASE   = 14'd100;
	localparam logic [13:0] OUT_NEG_MAX    = 14'd199;
	localparam logic [13:0] OUT_OC_ONLY    = 14'd93;
	localparam logic [6:0]  OUT_RUNNING    = 7'd0;
	localparam logic [6:0]  OUT_FAULT      = 7'd99;

	// ----------------------------------------------------------------
	// Input terminal function codes
	// ----------------------------------------------------------------
	localparam int unsigned NUM_TERM      = 5;
	localparam logic [7:0]  FUNC_SECOND   = 8'd3;
	localparam logic [7:0]  FUNC_JOG      = 8'd5;
	localparam logic [7:0]  FUNC_SHUTOFF  = 8'd24;
	localparam logic [7:0]  FUNC_STOP     = 8'd25;
	localparam logic [7:0]  FUNC_FWD      = 8'd60;
	localparam logic [7:0]  FUNC_REV      = 8'd61;
	localparam logic [7:0]  TERM_FIRST_INIT  = 8'd60;
	localparam logic [7:0]  TERM_SECOND_INIT = 8'd61;

	// ----------------------------------------------------------------
	// Drive state
	// ----------------------------------------------------------------
	typedef enum logic [2:0]
	{
		ST_IDLE  = 3'b000,
		ST_RUN   = 3'b001,
		ST_DECEL = 3'b010,
		ST_DELAY = 3'b011,
		ST_COAST = 3'b100
	} drive_state_t;

endpackage : start_stop_pkg

`default_nettype wire

/* File: tb/start_stop_logic_tb.sv */
// Self-checking bench for the start and stop command logic
`default_nettype none

module start_stop_logic_tb;
	timeunit 1ns;
	timeprecision 1ps;

	// Short second keeps the coast delays to a few dozen cycles
	localparam int unsigned SEC = 10;

	logic         sys_clk, nrst, jog_en, wr_s, wr_o, wr_r, fault;
	logic [7:0]   fsel, rsel;
	logic [23:0]  osel;
	logic [13:0]  disp, wdata, stop_rb, oc_rb, relay_rb;
	logic [99:0]  fstate;
	logic [4:0]   term_in;
	logic         run, rev, decel, coast, shut, second, oc_pin, relay_pin;
	int           err_total, num_checks;

	start_stop_logic #(.CYC_PER_SEC(SEC)) i_start_stop_logic
	(
		.sys_clk(sys_clk), .nrst(nrst), .term_in(term_in),
		.input_terminal_select_first(fsel), .input_terminal_select_second(rsel),
		.other_terminal_select(osel), .jog_enable(jog_en),
		.extended_display_select(disp), .stop_sel_wr(wr_s), .oc_sel_wr(wr_o),
		.relay_sel_wr(wr_r), .setting_wdata(wdata), .func_state(fstate),
		.fault_in(fault), .stop_selection_setting(stop_rb),
		.open_collector_output_select(oc_rb), .relay_output_select(relay_rb),
		.run_q(run), .dir_rev_q(rev), .decel_q(decel), .coast_q(coast),
		.shutoff_q(shut), .second_set_select(second),
		.open_collector_pin(oc_pin), .fault_relay_output(relay_pin)
	);

	start_switches i_start_switches
	(
		.sys_clk(sys_clk),
		.term_in(term_in)
	);

	// 200 MHz clock
	initial
	begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [13:0] exp, input logic [13:0] got);
		num_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// Sample a little after the edge so that its updates have landed
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : cyc

	// One setting write: 0 stop selection, 1 open collector, 2 relay
	task automatic wr(input int w, input logic [13:0] v);
		@(posedge sys_clk);
		wdata <= v;
		wr_s <= (w == 0);
		wr_o <= (w == 1);
		wr_r <= (w == 2);
		@(posedge sys_clk);
		{wr_s, wr_o, wr_r} <= 3'h0;
		cyc(2);
	endtask : wr

	// Drive flags packed as run, reverse, decel, coast
	task automatic cmd(input logic [3:0] exp);
		cyc(4);
		chk("cmd", {10'h000, exp}, {10'h000, run, rev, decel, coast});
	endtask : cmd

	// Start removed: delay shows as decel, coast follows after t seconds
	task automatic coast_after(input int t);
		cyc(t * SEC - 4);
		chk("delay", 14'h0002, {10'h000, run, rev, decel, coast});
		cyc(10);
		chk("coast", 14'h0001, {10'h000, run, rev, decel, coast});
	endtask : coast_after

	task automatic give_verdict();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : give_verdict

	// A hang costs one mismatch and ends the run the normal way
	initial
	begin
		#50us;
		err_total++;
		give_verdict();
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial
	begin
		{nrst, wr_s, wr_o, wr_r, fault, jog_en} = 6'h01;
		fsel = 8'h3c;
		rsel = 8'h3d;
		// Stop code stays off term 2 until the three-wire tests
		osel = {8'h05, 8'h18, 8'h1a};
		disp = 14'h0000;
		wdata = 14'h0000;
		fstate = '0;
		err_total = 0;
		num_checks = 0;
		repeat (2) @(posedge sys_clk);
		nrst <= 1'b1;
		cyc(1);
		chk("stop_sel", 14'h270f, stop_rb);
		chk("oc_sel", 14'h0000, oc_rb);
		chk("relay_sel", 14'h0063, relay_rb);
		fault <= 1'b1;
		cyc(3);
		chk("relay_pin", 14'h0001, {13'h0000, relay_pin});
		fault <= 1'b0;
		// Two-wire with deceleration
		i_start_switches.hold(5'h01);
		cmd(4'h8);
		i_start_switches.hold(5'h03);
		cmd(4'h2);
		i_start_switches.hold(5'h02);
		cmd(4'hc);
		i_start_switches.hold(5'h00);
		cmd(4'h6);
		// Timed coast, then run plus direction
		wr(0, 14'h0002);
		chk("stop_sel", 14'h0002, stop_rb);
		i_start_switches.hold(5'h01);
		cmd(4'h8);
		i_start_switches.hold(5'h00);
		coast_after(2);
		wr(0, 14'h03eb);
		i_start_switches.hold(5'h03);
		cmd(4'hc);
		i_start_switches.hold(5'h01);
		cmd(4'h8);
		i_start_switches.hold(5'h02);
		coast_after(3);
		wr(0, 14'h22b8);
		i_start_switches.hold(5'h03);
		cmd(4'hc);
		i_start_switches.hold(5'h00);
		cyc(30);
		chk("no_coast", 14'h0006, {10'h000, run, rev, decel, coast});
		// Refused writes
		wr(0, 14'h0065);
		wr(0, 14'h044d);
		wr(0, 14'h1388);
		chk("stop_sel", 14'h22b8, stop_rb);
		disp <= 14'h0001;
		wr(0, 14'h270f);
		chk("stop_sel", 14'h22b8, stop_rb);
		disp <= 14'h0000;
		wr(0, 14'h270f);
		chk("stop_sel", 14'h270f, stop_rb);
		wr(2, 14'h005d);
		wr(2, 14'h00c1);
		chk("relay_sel", 14'h0063, relay_rb);
		wr(2, 14'h270f);
		chk("relay_sel", 14'h270f, relay_rb);
		wr(1, 14'h005d);
		chk("oc_sel", 14'h005d, oc_rb);
		wr(1, 14'h01f4);
		chk("oc_sel", 14'h005d, oc_rb);
		// Output polarity
		wr(1, 14'h0001);
		fstate[1] <= 1'b1;
		cyc(3);
		chk("oc_pin", 14'h0001, {13'h0000, oc_pin});
		wr(1, 14'h0065);
		chk("oc_pin", 14'h0000, {13'h0000, oc_pin});
		fstate[1] <= 1'b0;
		cyc(3);
		chk("oc_pin", 14'h0001, {13'h0000, oc_pin});
		wr(2, 14'h0019);
		fstate <= {100{1'b1}};
		cyc(3);
		chk("relay_pin", 14'h0001, {13'h0000, relay_pin});
		fstate <= '0;
		cyc(3);
		chk("relay_pin", 14'h0000, {13'h0000, relay_pin});
		// Three-wire latching, stop function now on term 2
		@(posedge sys_clk);
		osel <= {8'h05, 8'h18, 8'h19};
		i_start_switches.hold(5'h04);
		i_start_switches.tap(3'h0);
		cmd(4'h8);
		i_start_switches.tap(3'h1);
		cmd(4'hc);
		i_start_switches.hold(5'h0c);
		cyc(4);
		chk("shutoff", 14'h0001, {13'h0000, shut});
		i_start_switches.hold(5'h04);
		cmd(4'hc);
		i_start_switches.hold(5'h00);
		cmd(4'h6);
		i_start_switches.hold(5'h04);
		i_start_switches.tap(3'h0);
		// Jog drops to two-wire, so the held forward level keeps it running
		i_start_switches.hold(5'h15);
		i_start_switches.hold(5'h11);
		cyc(4);
		chk("run_jog", 14'h0001, {13'h0000, run});
		jog_en <= 1'b0;
		cmd(4'h2);
		i_start_switches.hold(5'h00);
		// Terminal function codes
		@(posedge sys_clk);
		osel <= {8'h05, 8'h18, 8'h1a};
		i_start_switches.hold(5'h04);
		i_start_switches.tap(3'h0);
		cmd(4'h2);
		@(posedge sys_clk);
		osel <= {8'h03, 8'h18, 8'h1a};
		i_start_switches.hold(5'h10);
		cyc(4);
		chk("second", 14'h0001, {13'h0000, second});
		i_start_switches.hold(5'h00);
		cyc(4);
		chk("second", 14'h0000, {13'h0000, second});
		@(posedge sys_clk);
		fsel <= 8'h3d;
		rsel <= 8'h3c;
		i_start_switches.hold(5'h01);
		cmd(4'h2);
		i_start_switches.hold(5'h02);
		cmd(4'h2);
		give_verdict();
	end
endmodule : start_stop_logic_tb

`default_nettype wire

/* File: tb/start_switches.sv */
// Model of the external start, stop and function switches
`default_nettype none

module start_switches
(
	// Clock
	input  wire logic       sys_clk,
	// Terminal levels toward the drive
	output var  logic [4:0] term_in
);
	timeunit 1ns;
	timeprecision 1ps;

	// Contacts start open
	initial term_in = 5'h00;

	// Hold a set of levels; changes land just after an edge, never on it
	task automatic hold(input logic [4:0] lv);
		@(posedge sys_clk);
		term_in <= lv;
	endtask : hold

	// Close one contact for three cycles, then open it again
	task automatic tap(input logic [2:0] idx);
		@(posedge sys_clk);
		term_in <= term_in | (5'h01 << idx);
		repeat (3) @(posedge sys_clk);
		term_in <= term_in & ~(5'h01 << idx);
	endtask : tap
endmodule : start_switches

`default_nettype wire
